// [inc/mbs_pkg.sv]
package mbs_pkg;
   localparam logic [7:0]  FC_READ     = 8'h03;
   localparam logic [7:0]  FC_WRITE1   = 8'h06;
   localparam logic [7:0]  FC_LOOP     = 8'h08;
   localparam logic [7:0]  FC_WRITEN   = 8'h10;
   localparam logic [7:0]  EXC_FLAG    = 8'h80;
   localparam logic [7:0]  ERR_FUNC    = 8'h01;
   localparam logic [7:0]  ERR_ADDR    = 8'h02;
   localparam logic [7:0]  ERR_DATA    = 8'h03;
   localparam logic [7:0]  ASCII_HEAD  = 8'h3a;
   localparam logic [7:0]  ASCII_CR    = 8'h0d;
   localparam logic [7:0]  ASCII_LF    = 8'h0a;
   localparam logic [7:0]  BCAST_ADDR  = 8'h00;
   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'ha001;
   localparam logic [15:0] ONE_REG     = 16'h0001;
   localparam logic [7:0]  TWO_BYTES   = 8'h02;
   localparam int          BUF_BYTES   = 11;
   localparam logic [3:0]  BUF_LAST    = 4'ha;
   localparam logic [3:0]  MIN_FRAME   = 4'h4;
   localparam logic [3:0]  PAY_FIXED   = 4'h6;
   localparam logic [3:0]  PAY_MULTI   = 4'h9;
   localparam logic [2:0]  RSP_READ    = 3'h5;
   localparam logic [2:0]  RSP_ECHO    = 3'h6;
   localparam logic [2:0]  RSP_ERR     = 3'h3;
   localparam int          REG_AW      = 8;
   localparam int          REG_WORDS   = 256;
   localparam int          CLK_PERIOD_NS = 40;
   // One 11-bit character at 9600 baud
   localparam int          CHAR_TIME_NS  = 1145834;
   localparam int          GAP_TIME_NS   = CHAR_TIME_NS * 35 / 10;
   localparam int          GAP_CYCLES    = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          IDLE_W        = 24;

   typedef enum logic [1:0] {
      ST_RX    = 2'h0,
      ST_CHECK = 2'h1,
      ST_BUILD = 2'h2,
      ST_TX    = 2'h3
   } state_t;

   typedef enum logic [2:0] {
      TXP_HEAD = 3'h0,
      TXP_BODY = 3'h1,
      TXP_CR   = 3'h2,
      TXP_LF   = 3'h3,
      TXP_DONE = 3'h4
   } tx_phase_t;
endpackage

// [inc/reg_store_if.sv]
`timescale 1ns/1ns
interface reg_store_if;
   logic                      we;
   logic [mbs_pkg::REG_AW-1:0] addr;
   logic [15:0]               wdata;
   logic [15:0]               rdata;
   modport ctrl  (output we, output addr, output wdata, input rdata);
   modport store (input we, input addr, input wdata, output rdata);
endinterface

// [src/reg_store.sv]
`timescale 1ns/1ns
module reg_store (
   input  wire logic   clk_i,
   input  wire logic   ce_i,
   reg_store_if.store  port
);
   logic [15:0] mem_ff [0:mbs_pkg::REG_WORDS-1];
   logic [15:0] rdata_ff;

   // Read data is the word before any write in the same cycle
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         rdata_ff <= mem_ff[port.addr];
         if (port.we) begin
            mem_ff[port.addr] <= port.wdata;
         end
      end
   end

   assign port.rdata = rdata_ff;
endmodule

// [src/modbus_slave_command_handler.sv]
`timescale 1ns/1ns
module modbus_slave_command_handler #(
   parameter int unsigned GAP_CYCLES = mbs_pkg::GAP_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       ce_i,
   input  wire logic       ascii_mode_i,
   input  wire logic [7:0] slave_addr_i,
   input  wire logic       rx_valid_i,
   input  wire logic [7:0] rx_data_i,
   output logic            tx_valid_o,
   output logic [7:0]      tx_data_o,
   input  wire logic       tx_ready_i,
   output logic            reg_wr_o,
   output logic [15:0]     reg_wr_addr_o,
   output logic [15:0]     reg_wr_data_o
);
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ mbs_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   // Returns {valid, nibble} for an upper-case hex digit
   function automatic logic [4:0] hex_val(input logic [7:0] ch);
      logic [4:0] r;
      r = 5'h00;
      if (ch >= 8'h30 && ch <= 8'h39) begin
         r = {1'b1, ch[3:0]};
      end else if (ch >= 8'h41 && ch <= 8'h46) begin
         r = {1'b1, ch[3:0] + 4'h9};
      end
      return r;
   endfunction

   reg_store_if rs ();

   reg_store u_store (
      .clk_i (clk_i),
      .ce_i  (ce_i),
      .port  (rs.ctrl)
   );

   mbs_pkg::state_t    state_ff, nxt_state;
   mbs_pkg::tx_phase_t txph_ff, nxt_txph;
   logic [7:0]  buf_ff [0:mbs_pkg::BUF_BYTES-1];
   logic [7:0]  nxt_buf [0:mbs_pkg::BUF_BYTES-1];
   logic [7:0]  rsp_ff [0:5];
   logic [7:0]  nxt_rsp [0:5];
   logic [3:0]  cnt_ff, nxt_cnt;
   logic [15:0] crc_ff, nxt_crc;
   logic [7:0]  sum_ff, nxt_sum;
   logic [3:0]  nib_ff, nxt_nib;
   logic        half_ff, nxt_half;
   logic        inframe_ff, nxt_inframe;
   logic        cr_ff, nxt_cr;
   logic        ovf_ff, nxt_ovf;
   logic [mbs_pkg::IDLE_W-1:0] idle_ff, nxt_idle;
   logic [2:0]  rlen_ff, nxt_rlen;
   logic [7:0]  err_ff, nxt_err;
   logic        isread_ff, nxt_isread;
   logic [3:0]  tidx_ff, nxt_tidx;
   logic        thalf_ff, nxt_thalf;
   logic        tvalid_ff, nxt_tvalid;
   logic [7:0]  tdata_ff, nxt_tdata;
   logic        wr_ff, nxt_wr;
   logic [15:0] wra_ff, nxt_wra;
   logic [15:0] wrd_ff, nxt_wrd;

   logic [3:0]  pay;
   logic        sum_ok;
   logic [7:0]  fc;
   logic [4:0]  hv;
   logic [7:0]  cur;
   logic [3:0]  tlast;
   logic [7:0]  err;
   logic        wr_req;

   always_comb begin
      nxt_state   = state_ff;
      nxt_txph    = txph_ff;
      nxt_buf     = buf_ff;
      nxt_rsp     = rsp_ff;
      nxt_cnt     = cnt_ff;
      nxt_crc     = crc_ff;
      nxt_sum     = sum_ff;
      nxt_nib     = nib_ff;
      nxt_half    = half_ff;
      nxt_inframe = inframe_ff;
      nxt_cr      = cr_ff;
      nxt_ovf     = ovf_ff;
      nxt_idle    = idle_ff;
      nxt_rlen    = rlen_ff;
      nxt_err     = err_ff;
      nxt_isread  = isread_ff;
      nxt_tidx    = tidx_ff;
      nxt_thalf   = thalf_ff;
      nxt_tvalid  = tvalid_ff;
      nxt_tdata   = tdata_ff;
      nxt_wr      = 1'b0;
      nxt_wra     = wra_ff;
      nxt_wrd     = wrd_ff;
      rs.we       = 1'b0;
      rs.addr     = buf_ff[3];
      rs.wdata    = {buf_ff[4], buf_ff[5]};
      pay    = cnt_ff - (ascii_mode_i ? 4'h1 : 4'h2);
      sum_ok = ascii_mode_i ? (sum_ff == 8'h00 && !half_ff) : (crc_ff == 16'h0000);
      fc     = buf_ff[1];
      hv     = hex_val(rx_data_i);
      cur    = 8'h00;
      tlast  = 4'h0;
      err    = 8'h00;
      wr_req = 1'b0;
      case (state_ff)
         mbs_pkg::ST_RX: begin
            if (idle_ff != GAP_CYCLES[mbs_pkg::IDLE_W-1:0]) begin
               nxt_idle = idle_ff + 1'b1;
            end
            if (rx_valid_i) begin
               nxt_idle = '0;
               if (!ascii_mode_i) begin
                  if (cnt_ff <= mbs_pkg::BUF_LAST) begin
                     nxt_buf[cnt_ff] = rx_data_i;
                     nxt_cnt = cnt_ff + 4'h1;
                  end else begin
                     nxt_ovf = 1'b1;
                  end
                  nxt_crc = crc_step(crc_ff, rx_data_i);
               end else if (rx_data_i == mbs_pkg::ASCII_HEAD) begin
                  nxt_inframe = 1'b1;
                  nxt_cnt  = '0;
                  nxt_sum  = '0;
                  nxt_half = 1'b0;
                  nxt_cr   = 1'b0;
                  nxt_ovf  = 1'b0;
               end else if (inframe_ff && cr_ff) begin
                  nxt_inframe = 1'b0;
                  nxt_cr = 1'b0;
                  if (rx_data_i == mbs_pkg::ASCII_LF) begin
                     nxt_state = mbs_pkg::ST_CHECK;
                  end
               end else if (inframe_ff && rx_data_i == mbs_pkg::ASCII_CR) begin
                  nxt_cr = 1'b1;
               end else if (inframe_ff && hv[4]) begin
                  nxt_half = !half_ff;
                  nxt_nib  = hv[3:0];
                  if (half_ff) begin
                     if (cnt_ff <= mbs_pkg::BUF_LAST) begin
                        nxt_buf[cnt_ff] = {nib_ff, hv[3:0]};
                        nxt_cnt = cnt_ff + 4'h1;
                     end else begin
                        nxt_ovf = 1'b1;
                     end
                     nxt_sum = sum_ff + {nib_ff, hv[3:0]};
                  end
               end else begin
                  nxt_inframe = 1'b0;
               end
            end else if (!ascii_mode_i && cnt_ff != 4'h0 &&
                         idle_ff == GAP_CYCLES[mbs_pkg::IDLE_W-1:0]) begin
               nxt_state = mbs_pkg::ST_CHECK;
            end
         end
         mbs_pkg::ST_CHECK: begin
            nxt_state = mbs_pkg::ST_RX;
            if (sum_ok && !ovf_ff && cnt_ff >= mbs_pkg::MIN_FRAME &&
                slave_addr_i != mbs_pkg::BCAST_ADDR &&
                (buf_ff[0] == slave_addr_i || buf_ff[0] == mbs_pkg::BCAST_ADDR)) begin
               case (fc)
                  mbs_pkg::FC_READ: begin
                     if (pay != mbs_pkg::PAY_FIXED || {buf_ff[4], buf_ff[5]} != mbs_pkg::ONE_REG) begin
                        err = mbs_pkg::ERR_DATA;
                     end else if (buf_ff[2] != 8'h00) begin
                        err = mbs_pkg::ERR_ADDR;
                     end
                  end
                  mbs_pkg::FC_WRITE1: begin
                     if (pay != mbs_pkg::PAY_FIXED) begin
                        err = mbs_pkg::ERR_DATA;
                     end else if (buf_ff[2] != 8'h00) begin
                        err = mbs_pkg::ERR_ADDR;
                     end else begin
                        wr_req = 1'b1;
                     end
                  end
                  mbs_pkg::FC_LOOP: begin
                     if (pay != mbs_pkg::PAY_FIXED) begin
                        err = mbs_pkg::ERR_DATA;
                     end
                  end
                  mbs_pkg::FC_WRITEN: begin
                     if (pay != mbs_pkg::PAY_MULTI || {buf_ff[4], buf_ff[5]} != mbs_pkg::ONE_REG ||
                         buf_ff[6] != mbs_pkg::TWO_BYTES) begin
                        err = mbs_pkg::ERR_DATA;
                     end else if (buf_ff[2] != 8'h00) begin
                        err = mbs_pkg::ERR_ADDR;
                     end else begin
                        wr_req = 1'b1;
                        rs.wdata = {buf_ff[7], buf_ff[8]};
                     end
                  end
                  default: err = mbs_pkg::ERR_FUNC;
               endcase
               rs.we   = wr_req;
               nxt_wr  = wr_req;
               nxt_wra = {buf_ff[2], buf_ff[3]};
               nxt_wrd = rs.wdata;
               nxt_err = err;
               nxt_isread = (fc == mbs_pkg::FC_READ);
               if (buf_ff[0] != mbs_pkg::BCAST_ADDR) begin
                  nxt_state = mbs_pkg::ST_BUILD;
               end
            end
            nxt_cnt = '0;
            nxt_crc = mbs_pkg::CRC_INIT;
            nxt_ovf = 1'b0;
            nxt_idle = '0;
         end
         mbs_pkg::ST_BUILD: begin
            for (int i = 0; i < 6; i++) begin
               nxt_rsp[i] = buf_ff[i];
            end
            nxt_rlen = mbs_pkg::RSP_ECHO;
            if (err_ff != 8'h00) begin
               nxt_rsp[1] = buf_ff[1] | mbs_pkg::EXC_FLAG;
               nxt_rsp[2] = err_ff;
               nxt_rlen = mbs_pkg::RSP_ERR;
            end else if (isread_ff) begin
               nxt_rsp[2] = {buf_ff[5][6:0], 1'b0};
               nxt_rsp[3] = rs.rdata[15:8];
               nxt_rsp[4] = rs.rdata[7:0];
               nxt_rlen = mbs_pkg::RSP_READ;
            end
            nxt_tidx  = '0;
            nxt_thalf = 1'b0;
            nxt_sum   = '0;
            nxt_txph  = ascii_mode_i ? mbs_pkg::TXP_HEAD : mbs_pkg::TXP_BODY;
            nxt_state = mbs_pkg::ST_TX;
         end
         mbs_pkg::ST_TX: begin
            tlast = {1'b0, rlen_ff} + (ascii_mode_i ? 4'h0 : 4'h1);
            if (tidx_ff < {1'b0, rlen_ff}) begin
               cur = rsp_ff[tidx_ff[2:0]];
            end else if (ascii_mode_i) begin
               cur = 8'h00 - sum_ff;
            end else begin
               cur = (tidx_ff == {1'b0, rlen_ff}) ? crc_ff[7:0] : crc_ff[15:8];
            end
            if (!tvalid_ff || tx_ready_i) begin
               nxt_tvalid = 1'b1;
               case (txph_ff)
                  mbs_pkg::TXP_HEAD: begin
                     nxt_tdata = mbs_pkg::ASCII_HEAD;
                     nxt_txph  = mbs_pkg::TXP_BODY;
                  end
                  mbs_pkg::TXP_BODY: begin
                     nxt_tdata = ascii_mode_i ? hex_char(thalf_ff ? cur[3:0] : cur[7:4]) : cur;
                     nxt_thalf = ascii_mode_i && !thalf_ff;
                     if (!ascii_mode_i || thalf_ff) begin
                        if (tidx_ff < {1'b0, rlen_ff}) begin
                           nxt_crc = crc_step(crc_ff, cur);
                           nxt_sum = sum_ff + cur;
                        end
                        if (tidx_ff == tlast) begin
                           nxt_txph = ascii_mode_i ? mbs_pkg::TXP_CR : mbs_pkg::TXP_DONE;
                        end else begin
                           nxt_tidx = tidx_ff + 4'h1;
                        end
                     end
                  end
                  mbs_pkg::TXP_CR: begin
                     nxt_tdata = mbs_pkg::ASCII_CR;
                     nxt_txph  = mbs_pkg::TXP_LF;
                  end
                  mbs_pkg::TXP_LF: begin
                     nxt_tdata = mbs_pkg::ASCII_LF;
                     nxt_txph  = mbs_pkg::TXP_DONE;
                  end
                  default: begin
                     nxt_tvalid = 1'b0;
                     nxt_crc    = mbs_pkg::CRC_INIT;
                     nxt_idle   = '0;
                     nxt_state  = mbs_pkg::ST_RX;
                  end
               endcase
            end
         end
         default: nxt_state = mbs_pkg::ST_RX;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_ff   <= mbs_pkg::ST_RX;
         txph_ff    <= mbs_pkg::TXP_DONE;
         buf_ff     <= '{default: 8'h00};
         rsp_ff     <= '{default: 8'h00};
         cnt_ff     <= '0;
         crc_ff     <= mbs_pkg::CRC_INIT;
         sum_ff     <= '0;
         nib_ff     <= '0;
         half_ff    <= 1'b0;
         inframe_ff <= 1'b0;
         cr_ff      <= 1'b0;
         ovf_ff     <= 1'b0;
         idle_ff    <= '0;
         rlen_ff    <= '0;
         err_ff     <= '0;
         isread_ff  <= 1'b0;
         tidx_ff    <= '0;
         thalf_ff   <= 1'b0;
         tvalid_ff  <= 1'b0;
         tdata_ff   <= '0;
         wr_ff      <= 1'b0;
         wra_ff     <= '0;
         wrd_ff     <= '0;
      end else if (ce_i) begin
         state_ff   <= nxt_state;
         txph_ff    <= nxt_txph;
         buf_ff     <= nxt_buf;
         rsp_ff     <= nxt_rsp;
         cnt_ff     <= nxt_cnt;
         crc_ff     <= nxt_crc;
         sum_ff     <= nxt_sum;
         nib_ff     <= nxt_nib;
         half_ff    <= nxt_half;
         inframe_ff <= nxt_inframe;
         cr_ff      <= nxt_cr;
         ovf_ff     <= nxt_ovf;
         idle_ff    <= nxt_idle;
         rlen_ff    <= nxt_rlen;
         err_ff     <= nxt_err;
         isread_ff  <= nxt_isread;
         tidx_ff    <= nxt_tidx;
         thalf_ff   <= nxt_thalf;
         tvalid_ff  <= nxt_tvalid;
         tdata_ff   <= nxt_tdata;
         wr_ff      <= nxt_wr;
         wra_ff     <= nxt_wra;
         wrd_ff     <= nxt_wrd;
      end
   end

   assign tx_valid_o    = tvalid_ff;
   assign tx_data_o     = tdata_ff;
   assign reg_wr_o      = wr_ff;
   assign reg_wr_addr_o = wra_ff;
   assign reg_wr_data_o = wrd_ff;
endmodule

// [verification/mbs_handler_asserts.sv]
`timescale 1ns/1ns
module mbs_handler_asserts #(
   parameter int unsigned GAP_CYCLES = mbs_pkg::GAP_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        ce_i,
   input  wire logic        ascii_mode_i,
   input  wire logic [7:0]  slave_addr_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        tx_valid_o,
   input  wire logic [7:0]  tx_data_o,
   input  wire logic        tx_ready_i,
   input  wire logic        reg_wr_o,
   input  wire logic [15:0] reg_wr_addr_o,
   input  wire logic [15:0] reg_wr_data_o
);
   logic [31:0] idle_cnt_ff;
   logic [31:0] nxt_idle_cnt;
   logic [7:0]  frame_addr_ff;
   logic [7:0]  nxt_frame_addr;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // Idle time since the last received character, and the first byte after a gap
   always_comb begin
      nxt_idle_cnt   = idle_cnt_ff;
      nxt_frame_addr = frame_addr_ff;
      if (ce_i && rx_valid_i) begin
         nxt_idle_cnt = 32'h0;
         if (idle_cnt_ff >= 32'(GAP_CYCLES)) begin
            nxt_frame_addr = rx_data_i;
         end
      end else if (ce_i && idle_cnt_ff < 32'(GAP_CYCLES)) begin
         nxt_idle_cnt = idle_cnt_ff + 32'h1;
      end
      if (reset_i) begin
         nxt_idle_cnt   = 32'(GAP_CYCLES);
         nxt_frame_addr = 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      idle_cnt_ff   <= nxt_idle_cnt;
      frame_addr_ff <= nxt_frame_addr;
   end

   a_rtu_gap: assert property ($rose(tx_valid_o) && !ascii_mode_i |-> idle_cnt_ff >= 32'(GAP_CYCLES))
      else $error("reply started before the idle gap elapsed");
   a_rtu_own_addr: assert property ($rose(tx_valid_o) && !ascii_mode_i |-> tx_data_o == slave_addr_i)
      else $error("reply does not begin with own address");
   a_no_bcast_reply: assert property ($rose(tx_valid_o) && !ascii_mode_i |-> frame_addr_ff != 8'h00)
      else $error("reply sent to a broadcast frame");
   a_addr_zero_mute: assert property (slave_addr_i == 8'h00 |-> !tx_valid_o)
      else $error("reply sent while own address is zero");
   a_ascii_head: assert property ($rose(tx_valid_o) && ascii_mode_i |-> tx_data_o == 8'h3a)
      else $error("ASCII reply does not start with colon");
   a_ascii_chars: assert property (ascii_mode_i && tx_valid_o
      |-> tx_data_o inside {[8'h30:8'h39], [8'h41:8'h46], 8'h3a, 8'h0d, 8'h0a})
      else $error("ASCII reply carries a non hex character");
   a_ascii_tail: assert property (ascii_mode_i && tx_valid_o && tx_ready_i && tx_data_o == 8'h0d
      |=> tx_valid_o && tx_data_o == 8'h0a)
      else $error("carriage return not followed by line feed");
   a_ascii_end: assert property (ascii_mode_i && tx_valid_o && tx_ready_i && tx_data_o == 8'h0a |=> !tx_valid_o)
      else $error("reply continues after line feed");
   a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("offered character changed before acceptance");
   a_wr_pulse: assert property (reg_wr_o && ce_i |=> !reg_wr_o && $stable(reg_wr_addr_o) && $stable(reg_wr_data_o))
      else $error("register write pulse longer than one cycle");
   a_wr_page: assert property (reg_wr_o |-> reg_wr_addr_o[15:8] == 8'h00 && !tx_valid_o)
      else $error("register write outside the store or during reply");

   c_write: cover property (reg_wr_o);
   c_ascii_reply: cover property ($rose(tx_valid_o) && ascii_mode_i);
   c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule

bind modbus_slave_command_handler mbs_handler_asserts #(.GAP_CYCLES(GAP_CYCLES)) u_chk (
   .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .ascii_mode_i(ascii_mode_i), .slave_addr_i(slave_addr_i),
   .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
   .tx_ready_i(tx_ready_i), .reg_wr_o(reg_wr_o), .reg_wr_addr_o(reg_wr_addr_o), .reg_wr_data_o(reg_wr_data_o));

// [verification/mbs_master_model.sv]
`timescale 1ns/1ns
module mbs_master_model (
   input  wire logic       clk_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   output logic            tx_ready_o
);
   logic [7:0] enc_q[$];
   logic [7:0] rsp_q[$];
   logic       slow;

   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h00;
      tx_ready_o = 1'b1;
      slow       = 1'b0;
   end

   // Collects the reply; a slow master accepts only every other cycle
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) begin
         rsp_q.push_back(tx_data_i);
      end
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
   end

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction

   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ mbs_pkg::CRC_POLY) : (c >> 1);
         end
      end
      return c;
   endfunction

   // Frames a message; bad spoils the checksum
   task automatic build(input logic [7:0] b[$], input logic asc, input logic bad);
      logic [15:0] c;
      logic [7:0]  s;
      c = crc16(b) ^ {16{bad}};
      s = 8'h00;
      foreach (b[i]) s = s + b[i];
      s = (8'h00 - s) ^ {8{bad}};
      enc_q = {};
      if (asc) begin
         b.push_back(s);
         enc_q.push_back(8'h3a);
         foreach (b[i]) begin
            enc_q.push_back(hexc(b[i][7:4]));
            enc_q.push_back(hexc(b[i][3:0]));
         end
         enc_q.push_back(8'h0d);
         enc_q.push_back(8'h0a);
      end else begin
         enc_q = b;
         enc_q.push_back(c[7:0]);
         enc_q.push_back(c[15:8]);
      end
   endtask

   // One character per pulse; the line shows junk between characters
   task automatic send(input logic [7:0] b[$], input logic asc, input logic bad);
      rsp_q = {};
      build(b, asc, bad);
      foreach (enc_q[i]) begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_data_o  <= enc_q[i];
         @(posedge clk_i);
         rx_valid_o <= 1'b0;
         rx_data_o  <= ~enc_q[i];
      end
      // Line then stays quiet for the whole reply, well past the idle gap
   endtask
endmodule

// [verification/modbus_slave_command_handler_tb_top.sv]
`timescale 1ns/1ns
module modbus_slave_command_handler_tb_top;
   localparam int GAP = 20;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        ascii_mode_i = 1'b0;
   logic [7:0]  slave_addr_i = 8'h01;
   logic        rx_valid_i;
   logic [7:0]  rx_data_i;
   logic        tx_ready_i;
   logic        tx_valid_o;
   logic [7:0]  tx_data_o;
   logic        reg_wr_o;
   logic [15:0] reg_wr_addr_o;
   logic [15:0] reg_wr_data_o;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   int          wr_cnt = 0;
   int          failures = 0;
   int          total_checks = 0;

   always #20 clk_i = ~clk_i;

   modbus_slave_command_handler #(.GAP_CYCLES(GAP)) i_dut (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .ascii_mode_i(ascii_mode_i), .slave_addr_i(slave_addr_i),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
      .tx_ready_i(tx_ready_i), .reg_wr_o(reg_wr_o), .reg_wr_addr_o(reg_wr_addr_o), .reg_wr_data_o(reg_wr_data_o));

   mbs_master_model i_master (.clk_i(clk_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));

   always @(posedge clk_i) begin
      if (reg_wr_o === 1'b1) begin
         wr_cnt++;
         wr_addr = reg_wr_addr_o;
         wr_data = reg_wr_data_o;
      end
   end

   task automatic report_and_stop();
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for a full reply, then compares it character by character
   task automatic expect_rsp(input logic [7:0] b[$], input logic asc);
      int n;
      i_master.build(b, asc, 1'b0);
      n = 0;
      while (i_master.rsp_q.size() < i_master.enc_q.size() && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      repeat (40) @(posedge clk_i);
      check16(16'(i_master.rsp_q.size()), 16'(i_master.enc_q.size()));
      if (n >= 4000) begin
         failures++;
         report_and_stop();
      end
      foreach (i_master.enc_q[i]) check16({8'h00, i_master.rsp_q[i]}, {8'h00, i_master.enc_q[i]});
   endtask

   task automatic expect_none();
      repeat (GAP + 80) @(posedge clk_i);
      check16(16'(i_master.rsp_q.size()), 16'h0000);
   endtask

   task automatic set_mode(input logic asc, input logic [7:0] own);
      @(posedge clk_i);
      ascii_mode_i <= asc;
      slave_addr_i <= own;
   endtask

   task automatic s_write_read();
      i_master.send('{8'h01, 8'h06, 8'h00, 8'h20, 8'h00, 8'hc1}, 1'b0, 1'b0);
      expect_rsp('{8'h01, 8'h06, 8'h00, 8'h20, 8'h00, 8'hc1}, 1'b0);
      check16(wr_addr, 16'h0020);
      check16(wr_data, 16'h00c1);
      i_master.send('{8'h01, 8'h03, 8'h00, 8'h20, 8'h00, 8'h01}, 1'b0, 1'b0);
      expect_rsp('{8'h01, 8'h03, 8'h02, 8'h00, 8'hc1}, 1'b0);
   endtask

   task automatic s_multi();
      i_master.send('{8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02, 8'h13, 8'h88}, 1'b0, 1'b0);
      expect_rsp('{8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01}, 1'b0);
      check16(wr_addr, 16'h0002);
      check16(wr_data, 16'h1388);
      i_master.send('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 1'b0, 1'b0);
      expect_rsp('{8'h01, 8'h03, 8'h02, 8'h13, 8'h88}, 1'b0);
   endtask

   task automatic s_errors();
      int n;
      n = wr_cnt;
      i_master.send('{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0);
      expect_rsp('{8'h01, 8'h85, 8'h01}, 1'b0);
      i_master.send('{8'h01, 8'h06, 8'h01, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0);
      expect_rsp('{8'h01, 8'h86, 8'h02}, 1'b0);
      i_master.send('{8'h01, 8'h03, 8'h00, 8'h20, 8'h00, 8'h02}, 1'b0, 1'b0);
      expect_rsp('{8'h01, 8'h83, 8'h03}, 1'b0);
      i_master.send('{8'h01, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h04, 8'h13, 8'h88}, 1'b0, 1'b0);
      expect_rsp('{8'h01, 8'h90, 8'h03}, 1'b0);
      check16(16'(wr_cnt - n), 16'h0000);
   endtask

   task automatic s_ascii();
      set_mode(1'b1, 8'h01);
      i_master.slow = 1'b1;
      i_master.send('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b1, 1'b0);
      expect_rsp('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b1);
      i_master.send('{8'h01, 8'h08, 8'hff, 8'hff, 8'hab, 8'hcd}, 1'b1, 1'b0);
      expect_rsp('{8'h01, 8'h08, 8'hff, 8'hff, 8'hab, 8'hcd}, 1'b1);
      i_master.send('{8'h01, 8'h06, 8'h01, 8'h00, 8'h00, 8'h01}, 1'b1, 1'b0);
      expect_rsp('{8'h01, 8'h86, 8'h02}, 1'b1);
      i_master.send('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b1, 1'b1);
      expect_none();
      i_master.slow = 1'b0;
      set_mode(1'b0, 8'h01);
   endtask

   task automatic s_silent();
      int n;
      n = wr_cnt;
      i_master.send('{8'h01, 8'h06, 8'h00, 8'h30, 8'h12, 8'h34}, 1'b0, 1'b1);
      expect_none();
      check16(16'(wr_cnt - n), 16'h0000);
      // Twelve bytes overrun the frame buffer and must be dropped silently
      i_master.send('{8'h01, 8'h06, 8'h00, 8'h30, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc}, 1'b0, 1'b0);
      expect_none();
      i_master.send('{8'h00, 8'h06, 8'h00, 8'h31, 8'hab, 8'hcd}, 1'b0, 1'b0);
      expect_none();
      check16(16'(wr_cnt - n), 16'h0001);
      check16(wr_data, 16'habcd);
      i_master.send('{8'h02, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b0, 1'b0);
      expect_none();
      set_mode(1'b0, 8'h00);
      i_master.send('{8'h00, 8'h06, 8'h00, 8'h32, 8'h55, 8'h66}, 1'b0, 1'b0);
      expect_none();
      check16(16'(wr_cnt - n), 16'h0001);
      set_mode(1'b0, 8'h01);
   endtask

   initial begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      s_write_read();
      s_multi();
      s_errors();
      s_ascii();
      s_silent();
      report_and_stop();
   end
endmodule
